// [aaa_pkg.sv]
// Package with constants and types for the AND/ADD execution datapath.
package aaa_pkg;

    // Instruction word layout.
    localparam int INSN_W       = 14;
    localparam int DATA_W       = 8;
    localparam int ADDR_W       = 7;
    localparam int GRP_HI       = 13;
    localparam int GRP_LO       = 12;
    localparam int OPC_HI       = 11;
    localparam int OPC_LO       = 8;
    localparam int TARGET_BIT   = 7;

    // Group and operation codes.
    localparam logic [1:0] GRP_LITERAL  = 2'h3;
    localparam logic [1:0] GRP_BYTEREG  = 2'h0;
    localparam logic [3:0] OPC_AND_IMM  = 4'h9;
    localparam logic [3:0] OPC_ADD_REG  = 4'h7;
    localparam logic [3:0] OPC_AND_REG  = 4'h5;

    // Reset values and the phase wrap point.
    localparam logic [7:0] ACC_RESET    = 8'h00;
    localparam logic [1:0] PHASE_FIRST  = 2'h0;
    localparam logic [1:0] PHASE_LAST   = 2'h3;

    // Decoded operation kind.
    typedef enum logic [1:0] {
        AAA_OP_NONE,
        AAA_OP_AND_IMM,
        AAA_OP_ADD_REG,
        AAA_OP_AND_REG
    } aaa_op_e;

    // Status flag group.
    typedef struct packed {
        logic carryFlag;
        logic nibbleHalfFlag;
        logic zeroFlag;
    } aaa_flags_s;

    // Flag update enables.
    typedef struct packed {
        logic carryEn;
        logic nibbleHalfEn;
        logic zeroEn;
    } aaa_flag_en_s;

    // File register write request.
    typedef struct packed {
        logic             wrEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } aaa_fwrite_s;

endpackage : aaa_pkg

// [aaa_phase_counter.sv]
// Four-phase instruction cycle counter.
`timescale 1ns/10ps

module aaa_phase_counter
    import aaa_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    output logic [1:0]      phase
);

    // Current phase register and its next value.
    logic [1:0] phase_reg;
    logic [1:0] phase_next;

    // Next phase wraps from the last phase back to the first.
    always_comb begin
        phase_next = (phase_reg == PHASE_LAST) ? PHASE_FIRST : phase_reg + 2'h1;
    end

    // Register the phase.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= PHASE_FIRST;
        end else begin
            phase_reg <= phase_next;
        end
    end

    assign phase = phase_reg;

endmodule : aaa_phase_counter

// [aaa_and_add_alu.sv]
// Execution datapath for the immediate AND, register ADD and register AND operations.
`timescale 1ns/10ps

// Notes on behaviour
// [RULE1] Literal group 1001: AND immediate, zero flag.
// [RULE2] Immediate from instruction low byte into accumulator.
// [RULE3] Register group 0111: add, update all three flags.
// [RULE4] Add result target bit picks destination.
// [RULE5] Register group 0101: AND, zero flag only.
// [RULE6] AND result target bit picks destination.
// [RULE7] Seven-bit index; bit above is target.
// [RULE8] Four phases: decode, read, compute, write.
module aaa_and_add_alu
    import aaa_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic [INSN_W-1:0]   insnWord,
    output logic [ADDR_W-1:0]        fileRdAddr,
    input  wire logic [DATA_W-1:0]   fileRdData,
    output aaa_fwrite_s              fileWrite,
    output logic [DATA_W-1:0]        accOut,
    output aaa_flags_s               flagsOut,
    output logic [1:0]               phaseOut
);

    // Phase of the instruction cycle.
    logic [1:0]        phase;

    // Datapath state registers and their next values.
    aaa_op_e           op_reg,      op_next;      // Operation latched at decode.
    logic [DATA_W-1:0] imm_reg,     imm_next;     // Immediate operand.
    logic [ADDR_W-1:0] addr_reg,    addr_next;    // Register index.
    logic              toFile_reg,  toFile_next;  // Result goes to the file register.
    logic [DATA_W-1:0] opnd_reg,    opnd_next;    // Second operand after the read phase.
    logic [DATA_W-1:0] res_reg,     res_next;     // Computed result.
    aaa_flags_s        newFl_reg,   newFl_next;   // Computed flags.
    aaa_flag_en_s      flEn_reg,    flEn_next;    // Which flags the operation touches.
    logic [DATA_W-1:0] acc_reg,     acc_next;     // Accumulator.
    aaa_flags_s        flags_reg,   flags_next;   // Status flags.
    aaa_fwrite_s       fw_reg,      fw_next;      // File write request.

    // Decode helpers.
    logic [1:0]        insnGrp;
    logic [3:0]        insnOpc;
    logic [DATA_W:0]   sumWide;
    logic [4:0]        sumLow;

    // Phase counter shared by every operation.
    aaa_phase_counter aaa_phase_counter_i (
        .mclk  (mclk),
        .rst_n (rst_n),
        .phase (phase)
    );

    assign insnGrp = insnWord[GRP_HI:GRP_LO];
    assign insnOpc = insnWord[OPC_HI:OPC_LO];

    // Adder paths; the low nibble sum gives the half carry.
    assign sumWide = {1'b0, acc_reg} + {1'b0, opnd_reg};
    assign sumLow  = {1'b0, acc_reg[3:0]} + {1'b0, opnd_reg[3:0]};

    // Next-state logic for the whole cycle, one phase at a time.
    always_comb begin
        op_next     = op_reg;
        imm_next    = imm_reg;
        addr_next   = addr_reg;
        toFile_next = toFile_reg;
        opnd_next   = opnd_reg;
        res_next    = res_reg;
        newFl_next  = newFl_reg;
        flEn_next   = flEn_reg;
        acc_next    = acc_reg;
        flags_next  = flags_reg;
        fw_next     = '0;
        // [RULE8] phase sequencing
        case (phase)
            2'h0: begin
                // Decode: anything not handled here is ignored by this block.
                op_next = AAA_OP_NONE;
                // [RULE1] immediate AND match
                if (insnGrp == GRP_LITERAL && insnOpc == OPC_AND_IMM) begin
                    op_next = AAA_OP_AND_IMM;
                // [RULE3] register add match
                end else if (insnGrp == GRP_BYTEREG && insnOpc == OPC_ADD_REG) begin
                    op_next = AAA_OP_ADD_REG;
                // [RULE5] register AND match
                end else if (insnGrp == GRP_BYTEREG && insnOpc == OPC_AND_REG) begin
                    op_next = AAA_OP_AND_REG;
                end
                // [RULE2] immediate byte capture
                imm_next    = insnWord[DATA_W-1:0];
                // [RULE7] index and target bit
                addr_next   = insnWord[ADDR_W-1:0];
                toFile_next = insnWord[TARGET_BIT];
            end
            2'h1: begin
                // Read: literal for the immediate form, file data otherwise.
                opnd_next = (op_reg == AAA_OP_AND_IMM) ? imm_reg : fileRdData;
            end
            2'h2: begin
                // Compute the result and candidate flags.
                flEn_next  = '0;
                newFl_next = flags_reg;
                case (op_reg)
                    AAA_OP_ADD_REG: begin
                        // [RULE3] sum and flags
                        res_next                  = sumWide[DATA_W-1:0];
                        newFl_next.carryFlag      = sumWide[DATA_W];
                        newFl_next.nibbleHalfFlag = sumLow[4];
                        newFl_next.zeroFlag       = (sumWide[DATA_W-1:0] == 8'h00);
                        flEn_next                 = '{carryEn: 1'b1, nibbleHalfEn: 1'b1, zeroEn: 1'b1};
                    end
                    AAA_OP_AND_IMM, AAA_OP_AND_REG: begin
                        // [RULE5] AND with zero flag only
                        res_next            = acc_reg & opnd_reg;
                        newFl_next.zeroFlag = ((acc_reg & opnd_reg) == 8'h00);
                        flEn_next.zeroEn    = 1'b1;
                    end
                    default: begin
                        res_next = acc_reg;
                    end
                endcase
            end
            2'h3: begin
                // Write back the result and the touched flags.
                if (op_reg != AAA_OP_NONE) begin
                    if (flEn_reg.carryEn) begin
                        flags_next.carryFlag = newFl_reg.carryFlag;
                    end
                    if (flEn_reg.nibbleHalfEn) begin
                        flags_next.nibbleHalfFlag = newFl_reg.nibbleHalfFlag;
                    end
                    if (flEn_reg.zeroEn) begin
                        flags_next.zeroFlag = newFl_reg.zeroFlag;
                    end
                    // [RULE4] [RULE6] destination select
                    if (op_reg != AAA_OP_AND_IMM && toFile_reg) begin
                        fw_next.wrEn = 1'b1;
                        fw_next.addr = addr_reg;
                        fw_next.data = res_reg;
                    end else begin
                        // [RULE1] immediate result to accumulator
                        acc_next = res_reg;
                    end
                end
            end
            default: begin
                op_next = AAA_OP_NONE;
            end
        endcase
    end

    // Register all datapath state.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            op_reg     <= AAA_OP_NONE;
            imm_reg    <= '0;
            addr_reg   <= '0;
            toFile_reg <= 1'b0;
            opnd_reg   <= '0;
            res_reg    <= '0;
            newFl_reg  <= '0;
            flEn_reg   <= '0;
            acc_reg    <= ACC_RESET;
            flags_reg  <= '0;
            fw_reg     <= '0;
        end else begin
            op_reg     <= op_next;
            imm_reg    <= imm_next;
            addr_reg   <= addr_next;
            toFile_reg <= toFile_next;
            opnd_reg   <= opnd_next;
            res_reg    <= res_next;
            newFl_reg  <= newFl_next;
            flEn_reg   <= flEn_next;
            acc_reg    <= acc_next;
            flags_reg  <= flags_next;
            fw_reg     <= fw_next;
        end
    end

    // The file read address is held from decode, so it is stable in the read phase.
    assign fileRdAddr = addr_reg;
    assign fileWrite  = fw_reg;
    assign accOut     = acc_reg;
    assign flagsOut   = flags_reg;
    assign phaseOut   = phase;

    // Assertions.
    property p_phase_order;
        @(posedge mclk) disable iff (!rst_n) (phase == 2'h3) |=> (phase == 2'h0) ##1 (phase == 2'h1);
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("Phase did not wrap in order."); // [RULE8]

    property p_and_imm_result;
        @(posedge mclk) disable iff (!rst_n)
            (phase == 2'h0 && insnGrp == GRP_LITERAL && insnOpc == OPC_AND_IMM)
            |=> ##3 (accOut == ($past(accOut, 4) & $past(insnWord[7:0], 4)) && !fileWrite.wrEn);
    endproperty
    a_and_imm_result: assert property (p_and_imm_result) else $error("Immediate AND result wrong."); // [RULE2]

    property p_and_imm_flags;
        @(posedge mclk) disable iff (!rst_n)
            (phase == 2'h0 && insnGrp == GRP_LITERAL && insnOpc == OPC_AND_IMM)
            |=> ##3 (flagsOut.carryFlag == $past(flagsOut.carryFlag, 4)
                     && flagsOut.nibbleHalfFlag == $past(flagsOut.nibbleHalfFlag, 4)
                     && flagsOut.zeroFlag == (accOut == 8'h00));
    endproperty
    a_and_imm_flags: assert property (p_and_imm_flags) else $error("Immediate AND flag update wrong."); // [RULE1]

    property p_add_flags;
        @(posedge mclk) disable iff (!rst_n)
            (phase == 2'h3 && op_reg == AAA_OP_ADD_REG)
            |=> (flagsOut.carryFlag == $past(sumWide[8]) && flagsOut.nibbleHalfFlag == $past(sumLow[4])
                 && flagsOut.zeroFlag == ($past(res_reg) == 8'h00));
    endproperty
    a_add_flags: assert property (p_add_flags) else $error("Add flags not taken from the sum."); // [RULE3]

    property p_add_dest;
        @(posedge mclk) disable iff (!rst_n)
            (phase == 2'h3 && op_reg == AAA_OP_ADD_REG && toFile_reg)
            |=> (fileWrite.wrEn && fileWrite.addr == $past(addr_reg) && accOut == $past(acc_reg));
    endproperty
    a_add_dest: assert property (p_add_dest) else $error("Add result to file register missing."); // [RULE4]

    property p_and_reg_flags;
        @(posedge mclk) disable iff (!rst_n)
            (phase == 2'h3 && op_reg == AAA_OP_AND_REG)
            |=> ($stable(flagsOut.carryFlag) && $stable(flagsOut.nibbleHalfFlag));
    endproperty
    a_and_reg_flags: assert property (p_and_reg_flags) else $error("Register AND touched carry or half flag."); // [RULE5]

    property p_and_reg_dest;
        @(posedge mclk) disable iff (!rst_n)
            (phase == 2'h3 && op_reg == AAA_OP_AND_REG && !toFile_reg)
            |=> (!fileWrite.wrEn && accOut == $past(res_reg));
    endproperty
    a_and_reg_dest: assert property (p_and_reg_dest) else $error("Register AND result to accumulator missing."); // [RULE6]

    property p_index_decode;
        @(posedge mclk) disable iff (!rst_n)
            (phase == 2'h0) |=> (fileRdAddr == $past(insnWord[6:0]) && toFile_reg == $past(insnWord[7]));
    endproperty
    a_index_decode: assert property (p_index_decode) else $error("Register index or target bit not decoded."); // [RULE7]

endmodule : aaa_and_add_alu

// [aaa_file_bank.sv]
// Behavioural model of the file register bank that feeds and absorbs the datapath.
`timescale 1ns/10ps

module aaa_file_bank
    import aaa_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic [1:0]        phase,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic [DATA_W-1:0]      rdData,
    input  wire aaa_fwrite_s       fileWrite
);
    // Register contents; the bench loads them at time zero.
    logic [DATA_W-1:0] mem [0:127];

    // Data is only promised in the read phase.
    // Elsewhere the inverse shows, so a sample taken in the wrong phase is caught.
    always_comb begin
        rdData = (phase == 2'h1) ? mem[rdAddr] : ~mem[rdAddr];
    end

    // A write lands on the edge that sees the one-cycle strobe.
    always @(posedge mclk) begin
        if (fileWrite.wrEn === 1'b1) begin
            mem[fileWrite.addr] <= fileWrite.data;
        end
    end
endmodule : aaa_file_bank

// [aaa_and_add_alu_ops_bench.sv]
// Self-checking bench for the AND/ADD execution datapath.
`timescale 1ns/10ps

module aaa_and_add_alu_ops_bench
    import aaa_pkg::*;
;
    // Expected outcome of one instruction.
    typedef struct packed {
        logic [DATA_W-1:0] acc;
        aaa_flags_s        fl;
        aaa_fwrite_s       fw;
    } aaa_expect_s;

    logic              mclk;
    logic              rst_n;
    logic [INSN_W-1:0] insnWord;
    logic [ADDR_W-1:0] fileRdAddr;
    logic [DATA_W-1:0] fileRdData;
    aaa_fwrite_s       fileWrite;
    logic [DATA_W-1:0] accOut;
    aaa_flags_s        flagsOut;
    logic [1:0]        phaseOut;
    aaa_expect_s       expQ [$];        // Notes waiting for their result.
    aaa_expect_s       model;           // Running reference state.
    aaa_expect_s       head;            // Note being compared.
    logic [DATA_W-1:0] shadow [0:127];  // Reference copy of the bank.
    logic [1:0]        prevPhase;
    logic [31:0]       r;
    int                errors;
    int                nTests;
    int                cycles;
    int                seed;

    aaa_and_add_alu aaa_and_add_alu_i (.mclk(mclk), .rst_n(rst_n), .insnWord(insnWord),
        .fileRdAddr(fileRdAddr), .fileRdData(fileRdData), .fileWrite(fileWrite),
        .accOut(accOut), .flagsOut(flagsOut), .phaseOut(phaseOut));

    aaa_file_bank aaa_file_bank_i (.mclk(mclk), .phase(phaseOut), .rdAddr(fileRdAddr),
        .rdData(fileRdData), .fileWrite(fileWrite));

    // Free-running 20 MHz clock.
    initial mclk = 1'b0;
    always #25 mclk = ~mclk;

    // Prints the verdict and ends the run.
    task automatic give_verdict();
        if (errors == 0 && nTests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Compares one value and counts the outcome.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Issues one instruction for a full four-phase cycle and notes its outcome.
    task automatic exec(input logic [INSN_W-1:0] insn);
        logic [8:0] sum;
        logic [7:0] res;
        logic [6:0] f;
        f = insn[6:0];
        model.fw = '0;
        sum = {1'b0, model.acc} + {1'b0, shadow[f]};
        if (insn[13:12] == GRP_LITERAL && insn[11:8] == OPC_AND_IMM) begin
            model.acc = model.acc & insn[7:0];
            model.fl.zeroFlag = (model.acc == 8'h00);
        end else if (insn[13:12] == GRP_BYTEREG && (insn[11:8] == OPC_ADD_REG || insn[11:8] == OPC_AND_REG)) begin
            res = (insn[11:8] == OPC_ADD_REG) ? sum[7:0] : (model.acc & shadow[f]);
            if (insn[11:8] == OPC_ADD_REG) begin
                model.fl.carryFlag = sum[8];
                model.fl.nibbleHalfFlag = ({1'b0, model.acc[3:0]} + {1'b0, shadow[f][3:0]}) > 5'h0F;
            end
            model.fl.zeroFlag = (res == 8'h00);
            if (insn[TARGET_BIT]) begin
                model.fw = '{wrEn: 1'b1, addr: f, data: res};
                shadow[f] = res;
            end else begin
                model.acc = res;
            end
        end
        expQ.push_back(model);
        insnWord <= insn;
        repeat (4) @(posedge mclk);
    endtask : exec

    // Watcher: settles past each edge, then checks results and mid-cycle behaviour.
    always @(posedge mclk) begin
        #1;
        cycles++;
        if (cycles > 5000) begin
            errors++;
            give_verdict();
        end
        if (rst_n === 1'b1 && phaseOut === 2'h0 && prevPhase === 2'h3) begin
            head = expQ.pop_front();
            check("accumulator", {8'h00, accOut}, {8'h00, head.acc});
            check("flags", {13'h0000, flagsOut}, {13'h0000, head.fl});
            check("write strobe", {15'h0000, fileWrite.wrEn}, {15'h0000, head.fw.wrEn});
            if (head.fw.wrEn) begin
                check("write word", fileWrite, head.fw);
            end
        end
        if (rst_n === 1'b1 && phaseOut === 2'h1) begin
            // The strobe must have dropped after one cycle.
            check("strobe length", {15'h0000, fileWrite.wrEn}, 16'h0000);
            if (insnWord[13:12] == GRP_BYTEREG) begin
                check("register index", {9'h000, fileRdAddr}, {9'h000, insnWord[6:0]});
            end
        end
        prevPhase = phaseOut;
    end

    // Main sequence: reset, directed corners, then random traffic.
    initial begin
        rst_n = 1'b0;
        insnWord = '0;
        seed = 32'h5054cd6b;
        errors = 0;
        nTests = 0;
        cycles = 0;
        prevPhase = 2'h0;
        model = '0;
        for (int a = 0; a < 128; a++) begin
            shadow[a] = 8'($random(seed));
            aaa_file_bank_i.mem[a] = shadow[a];
        end
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        // Index boundaries, a zero result and a near-miss opcode come first.
        exec({GRP_BYTEREG, OPC_ADD_REG, 1'b0, 7'h7F});
        exec({GRP_LITERAL, OPC_AND_IMM, 8'h00});
        exec({GRP_BYTEREG, OPC_ADD_REG, 1'b0, 7'h00});
        exec({GRP_BYTEREG, OPC_AND_REG, 1'b1, 7'h7F});
        exec({GRP_BYTEREG, OPC_ADD_REG, 1'b1, 7'h7F});
        exec({GRP_LITERAL, 4'h8, 8'h00});
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            case (r[18:16])
                3'h0, 3'h1: begin
                    exec({GRP_LITERAL, OPC_AND_IMM, r[7:0]});
                end
                3'h2, 3'h3: begin
                    exec({GRP_BYTEREG, OPC_ADD_REG, r[7:0]});
                end
                3'h4, 3'h5: begin
                    exec({GRP_BYTEREG, OPC_AND_REG, r[7:0]});
                end
                default: begin
                    // Mostly words that must change nothing; the model sorts them.
                    exec(r[13:0]);
                end
            endcase
        end
        repeat (2) @(posedge mclk);
        check("leftover notes", 16'(expQ.size()), 16'h0000);
        give_verdict();
    end
endmodule : aaa_and_add_alu_ops_bench
